// ### phy_cable_diag_vendor_regs.sv
/*
 * vendor registers 24..28: cable test sequencer, invalid symbol tally, crossover, heartbeat, polarity, length.
 * assumes mdc, mdio_in and status inputs synchronous to clock; analog front end reports via tdr_result_valid.
 */
`timescale 1ns/10ps
module phy_cable_diag_vendor_regs #(
    parameter int BREAK_BASE_CYC = phy_diag_pkg::BREAK_BASE_CYC,
    parameter int BREAK_STEP_CYC = phy_diag_pkg::BREAK_STEP_CYC,
    parameter int SAMPLE_W = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_n,
    input wire logic [4:0] station_address,
    output logic tdr_line_break,
    output logic tdr_pulse_active,
    input wire logic tdr_cycle_high,
    output logic [5:0] tdr_tx_pattern,
    input wire logic [SAMPLE_W-1:0] tdr_sample,
    output logic [SAMPLE_W-1:0] tdr_sample_filt,
    input wire logic tdr_result_valid,
    input wire logic [1:0] tdr_result_type,
    input wire logic [7:0] tdr_result_length,
    input wire logic link_100tx,
    input wire logic link_10t,
    input wire logic rx_in_packet,
    input wire logic rx_symbol_invalid,
    input wire logic auto_crossed,
    output logic pair_crossed,
    output logic auto_crossover_en,
    output logic heartbeat_test_en,
    input wire logic rx_polarity_reversed,
    input wire logic [3:0] cable_length_in
);
    if (BREAK_BASE_CYC < 1 || BREAK_STEP_CYC < 1 || SAMPLE_W < 2) begin : g_bad_params
        $error("unsupported parameter values");
    end

    typedef enum logic [3:0] {m_pre = 4'h1, m_hdr = 4'h2, m_ta = 4'h4, m_data = 4'h8} mgmt_state_t;

    typedef enum logic [2:0] {t_idle = 3'h1, t_break = 3'h2, t_test = 3'h4} tdr_state_t;

    // median of three: one-sample spikes never reach the output; a tie must still yield the shared value
    function automatic logic [SAMPLE_W-1:0] median3(input logic [SAMPLE_W-1:0] a, b, c);
        if (!(a < b && a < c) && !(a > b && a > c))
            median3 = a;
        else if (!(b < a && b < c) && !(b > a && b > c))
            median3 = b;
        else
            median3 = c;
    endfunction

    // registers
    logic [15:0] pd_ff, tc_ff, sym_ff, xc_ff;
    logic [15:0] nxt_pd, nxt_tc, nxt_sym, nxt_xc;
    logic pkt_counted_ff, nxt_pkt_counted;
    // management frame
    mgmt_state_t ms_ff, nxt_ms;
    logic mdc_prev_ff;
    logic [5:0] bit_cnt_ff, nxt_bit_cnt;
    logic [15:0] shift_ff, nxt_shift;
    logic is_read_ff, nxt_is_read, hit_ff, nxt_hit;
    logic [4:0] reg_idx_ff, nxt_reg_idx, wr_idx;
    logic mdio_out_ff, nxt_mdio_out, mdio_oe_n_ff, nxt_mdio_oe_n;
    logic wr_en, tdr_done, mdc_rise;
    logic [15:0] wr_data;
    // cable test
    tdr_state_t ts_ff, nxt_ts;
    logic [31:0] tmr_ff, nxt_tmr;
    logic [5:0] pat_ff, nxt_pat;
    logic [SAMPLE_W-1:0] s1_ff, s2_ff, filt_ff, nxt_filt;

    function automatic logic [15:0] reg_read(input logic [4:0] idx, input logic [15:0] pd, input logic [15:0] tc,
                                             input logic [15:0] sym, input logic [15:0] xc, input logic pol,
                                             input logic [3:0] cbl);
        case (idx)
            phy_diag_pkg::IDX_TDR_PATTERN_DELAY_CTRL: reg_read = pd;
            phy_diag_pkg::IDX_TDR_CTRL_STATUS: reg_read = tc & phy_diag_pkg::TC_WMASK;
            phy_diag_pkg::IDX_SYMBOL_ERROR_COUNTER: reg_read = sym;
            phy_diag_pkg::IDX_CROSSOVER_SQE_POLARITY_CTRL:
                reg_read = (xc & phy_diag_pkg::XC_WMASK) | (16'(pol) << phy_diag_pkg::XC_POL_BIT);
            phy_diag_pkg::IDX_CABLE_LENGTH_ESTIMATE: reg_read = 16'(cbl) << phy_diag_pkg::CBL_LSB;
            default: reg_read = 16'h0000;
        endcase
    endfunction

    assign mdc_rise = mdc & ~mdc_prev_ff;

    // management serial slave
    always_comb begin
        nxt_ms = ms_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_shift = shift_ff;
        nxt_is_read = is_read_ff;
        nxt_hit = hit_ff;
        nxt_reg_idx = reg_idx_ff;
        nxt_mdio_out = mdio_out_ff;
        nxt_mdio_oe_n = mdio_oe_n_ff;
        wr_en = 1'b0;
        wr_idx = reg_idx_ff;
        wr_data = {shift_ff[14:0], mdio_in};
        if (mdc_rise) begin
            case (ms_ff)
                m_pre: begin
                    if (mdio_in) begin
                        if (bit_cnt_ff < 6'(phy_diag_pkg::PREAMBLE_BITS))
                            nxt_bit_cnt = bit_cnt_ff + 6'h01;
                    end else if (bit_cnt_ff == 6'(phy_diag_pkg::PREAMBLE_BITS)) begin
                        nxt_ms = m_hdr;
                        nxt_bit_cnt = 6'h01;
                        nxt_shift = 16'h0000;
                    end else begin
                        nxt_bit_cnt = 6'h00;
                    end
                end
                m_hdr: begin
                    nxt_shift = {shift_ff[14:0], mdio_in};
                    nxt_bit_cnt = bit_cnt_ff + 6'h01;
                    if (bit_cnt_ff == 6'(phy_diag_pkg::HDR_BITS - 1)) begin
                        nxt_ms = m_ta;
                        nxt_bit_cnt = 6'h00;
                        nxt_reg_idx = nxt_shift[4:0];
                        nxt_is_read = nxt_shift[11:10] == phy_diag_pkg::OP_READ;
                        nxt_hit = nxt_shift[13:12] == phy_diag_pkg::FRAME_START
                            && nxt_shift[9:5] == station_address
                            && (nxt_shift[11:10] == phy_diag_pkg::OP_READ
                                || nxt_shift[11:10] == phy_diag_pkg::OP_WRITE);
                    end
                end
                m_ta: begin
                    nxt_bit_cnt = bit_cnt_ff + 6'h01;
                    if (bit_cnt_ff == 6'h00) begin
                        // second turnaround bit: drive zero on a read
                        if (hit_ff && is_read_ff) begin
                            nxt_mdio_out = 1'b0;
                            nxt_mdio_oe_n = 1'b0;
                            nxt_shift = reg_read(reg_idx_ff, pd_ff, tc_ff, sym_ff, xc_ff, rx_polarity_reversed,
                                                 (link_100tx && !link_10t) ? cable_length_in : 4'h0);
                        end
                    end else begin
                        nxt_ms = m_data;
                        nxt_bit_cnt = 6'h00;
                        if (hit_ff && is_read_ff) begin
                            nxt_mdio_out = shift_ff[15];
                            nxt_shift = {shift_ff[14:0], 1'b0};
                        end
                    end
                end
                m_data: begin
                    nxt_bit_cnt = bit_cnt_ff + 6'h01;
                    if (hit_ff && is_read_ff) begin
                        nxt_mdio_out = shift_ff[15];
                        nxt_shift = {shift_ff[14:0], 1'b0};
                    end else begin
                        nxt_shift = wr_data;
                    end
                    if (bit_cnt_ff == 6'(phy_diag_pkg::DATA_BITS - 1)) begin
                        wr_en = hit_ff & ~is_read_ff;
                        nxt_ms = m_pre;
                        nxt_bit_cnt = 6'h00;
                        nxt_mdio_oe_n = 1'b1;
                        nxt_mdio_out = 1'b0;
                    end
                end
                default: begin
                    nxt_ms = m_pre;
                    nxt_bit_cnt = 6'h00;
                    nxt_mdio_oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ms_ff <= m_pre;
            mdc_prev_ff <= 1'b0;
            bit_cnt_ff <= 6'h00;
            shift_ff <= 16'h0000;
            is_read_ff <= 1'b0;
            hit_ff <= 1'b0;
            reg_idx_ff <= 5'h00;
            mdio_out_ff <= 1'b0;
            mdio_oe_n_ff <= 1'b1;
        end else begin
            ms_ff <= nxt_ms;
            mdc_prev_ff <= mdc;
            bit_cnt_ff <= nxt_bit_cnt;
            shift_ff <= nxt_shift;
            is_read_ff <= nxt_is_read;
            hit_ff <= nxt_hit;
            reg_idx_ff <= nxt_reg_idx;
            mdio_out_ff <= nxt_mdio_out;
            mdio_oe_n_ff <= nxt_mdio_oe_n;
        end
    end

    // cable test sequencer
    assign tdr_done = (ts_ff == t_test) && tdr_result_valid;

    always_comb begin
        nxt_ts = ts_ff;
        nxt_tmr = tmr_ff;
        nxt_pat = tdr_cycle_high ? pd_ff[phy_diag_pkg::PD_PAT_HI_LSB +: 6]
                                 : pd_ff[phy_diag_pkg::PD_PAT_LO_LSB +: 6];
        nxt_filt = tc_ff[phy_diag_pkg::TC_FILTER_BIT] ? median3(tdr_sample, s1_ff, s2_ff) : tdr_sample;
        case (ts_ff)
            t_idle: begin
                if (tc_ff[phy_diag_pkg::TC_ENABLE_BIT]) begin
                    nxt_ts = t_break;
                    nxt_tmr = 32'(BREAK_BASE_CYC) - 32'h1;
                    if (pd_ff[phy_diag_pkg::PD_DELAY_EXT_BIT])
                        nxt_tmr = 32'(BREAK_BASE_CYC) - 32'h1
                            + 32'(pd_ff[phy_diag_pkg::PD_BREAK_CNT_LSB +: 3]) * 32'(BREAK_STEP_CYC);
                end
            end
            t_break: begin
                if (!tc_ff[phy_diag_pkg::TC_ENABLE_BIT])
                    nxt_ts = t_idle;
                else if (tmr_ff == 32'h0)
                    nxt_ts = t_test;
                else
                    nxt_tmr = tmr_ff - 32'h1;
            end
            t_test: begin
                if (!tc_ff[phy_diag_pkg::TC_ENABLE_BIT] || tdr_result_valid)
                    nxt_ts = t_idle;
            end
            default: nxt_ts = t_idle;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ts_ff <= t_idle;
            tmr_ff <= 32'h0;
            pat_ff <= 6'h00;
            s1_ff <= '0;
            s2_ff <= '0;
            filt_ff <= '0;
        end else begin
            ts_ff <= nxt_ts;
            tmr_ff <= nxt_tmr;
            pat_ff <= nxt_pat;
            s1_ff <= tdr_sample;
            s2_ff <= s1_ff;
            filt_ff <= nxt_filt;
        end
    end

    // register bank
    always_comb begin
        nxt_pd = pd_ff;
        nxt_tc = tc_ff;
        nxt_xc = xc_ff;
        nxt_sym = sym_ff;
        nxt_pkt_counted = pkt_counted_ff & rx_in_packet;
        if (wr_en) begin
            case (wr_idx)
                phy_diag_pkg::IDX_TDR_PATTERN_DELAY_CTRL: nxt_pd = wr_data & phy_diag_pkg::PD_WMASK;
                phy_diag_pkg::IDX_TDR_CTRL_STATUS: begin
                    nxt_tc = wr_data & phy_diag_pkg::TC_WMASK;
                    if (wr_data[phy_diag_pkg::TC_ENABLE_BIT] && !tc_ff[phy_diag_pkg::TC_ENABLE_BIT])
                        nxt_tc[phy_diag_pkg::TC_DONE_BIT] = 1'b0;
                end
                phy_diag_pkg::IDX_CROSSOVER_SQE_POLARITY_CTRL: nxt_xc = wr_data & phy_diag_pkg::XC_WMASK;
                default: ;
            endcase
        end
        // completion outranks a same-cycle write
        if (tdr_done) begin
            nxt_tc[phy_diag_pkg::TC_ENABLE_BIT] = 1'b0;
            nxt_tc[phy_diag_pkg::TC_DONE_BIT] = 1'b1;
            nxt_tc[phy_diag_pkg::TC_TYPE_LSB +: 2] = tdr_result_type;
            if (tdr_result_type == phy_diag_pkg::CABLE_SHORT || tdr_result_type == phy_diag_pkg::CABLE_OPEN)
                nxt_tc[phy_diag_pkg::TC_LEN_LSB +: 8] = tdr_result_length;
        end
        // tally on a 100TX link only: once per packet, every hit between packets, wraps naturally
        if (rx_symbol_invalid && link_100tx && !link_10t && !(rx_in_packet && pkt_counted_ff)) begin
            nxt_sym = sym_ff + 16'h0001;
            nxt_pkt_counted = rx_in_packet;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pd_ff <= phy_diag_pkg::PD_RESET;
            tc_ff <= phy_diag_pkg::TC_RESET;
            xc_ff <= phy_diag_pkg::XC_RESET;
            sym_ff <= phy_diag_pkg::SYM_RESET;
            pkt_counted_ff <= 1'b0;
        end else begin
            pd_ff <= nxt_pd;
            tc_ff <= nxt_tc;
            xc_ff <= nxt_xc;
            sym_ff <= nxt_sym;
            pkt_counted_ff <= nxt_pkt_counted;
        end
    end

    assign mdio_out = mdio_out_ff;
    assign mdio_oe_n = mdio_oe_n_ff;
    assign tdr_line_break = ts_ff == t_break;
    assign tdr_pulse_active = ts_ff == t_test;
    assign tdr_tx_pattern = pat_ff;
    assign tdr_sample_filt = filt_ff;
    assign auto_crossover_en = ~xc_ff[phy_diag_pkg::XC_AUTO_DIS_BIT];
    assign pair_crossed = xc_ff[phy_diag_pkg::XC_AUTO_DIS_BIT] ? xc_ff[phy_diag_pkg::XC_PAIR_SEL_BIT]
                                                                : auto_crossed;
    assign heartbeat_test_en = ~xc_ff[phy_diag_pkg::XC_SQE_OFF_BIT];
endmodule

// ### phy_diag_pkg.sv
/*
 * constants for the cable diagnostic / vendor management register bank:
 * register indices, field positions, reset values, management frame codes, timing figures.
 * assumes a 125 MHz core clock and 16-bit management registers.
 */
package phy_diag_pkg;
    localparam int CLK_MHZ = 125;
    localparam int REG_W = 16;

    // register indices on the management bus
    localparam logic [4:0] IDX_TDR_PATTERN_DELAY_CTRL = 5'h18;
    localparam logic [4:0] IDX_TDR_CTRL_STATUS = 5'h19;
    localparam logic [4:0] IDX_SYMBOL_ERROR_COUNTER = 5'h1a;
    localparam logic [4:0] IDX_CROSSOVER_SQE_POLARITY_CTRL = 5'h1b;
    localparam logic [4:0] IDX_CABLE_LENGTH_ESTIMATE = 5'h1c;

    // pattern/delay register fields
    localparam int PD_DELAY_EXT_BIT = 15;
    localparam int PD_BREAK_CNT_LSB = 12;
    localparam int PD_PAT_HI_LSB = 6;
    localparam int PD_PAT_LO_LSB = 0;
    localparam logic [15:0] PD_RESET = 16'h0b9d;
    localparam logic [15:0] PD_WMASK = 16'hffff;

    // control/status register fields
    localparam int TC_ENABLE_BIT = 15;
    localparam int TC_FILTER_BIT = 14;
    localparam int TC_TYPE_LSB = 9;
    localparam int TC_DONE_BIT = 8;
    localparam int TC_LEN_LSB = 0;
    localparam logic [15:0] TC_RESET = 16'h0000;
    localparam logic [15:0] TC_WMASK = 16'hc7ff;

    // cable type codes
    localparam logic [1:0] CABLE_DEFAULT = 2'h0;
    localparam logic [1:0] CABLE_SHORT = 2'h1;
    localparam logic [1:0] CABLE_OPEN = 2'h2;
    localparam logic [1:0] CABLE_MATCH = 2'h3;

    // crossover / heartbeat / polarity register fields
    localparam int XC_AUTO_DIS_BIT = 15;
    localparam int XC_PAIR_SEL_BIT = 13;
    localparam int XC_SQE_OFF_BIT = 11;
    localparam int XC_POL_BIT = 4;
    localparam logic [15:0] XC_RESET = 16'h0000;
    localparam logic [15:0] XC_WMASK = 16'ha800;

    localparam int CBL_LSB = 12;
    localparam logic [15:0] SYM_RESET = 16'h0000;

    // management frame
    localparam int PREAMBLE_BITS = 32;
    localparam int HDR_BITS = 14;
    localparam int DATA_BITS = 16;
    localparam logic [1:0] FRAME_START = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;

    // line break timing
    localparam int BREAK_BASE_MS = 2;
    localparam int BREAK_STEP_MS = 256;
    localparam int BREAK_BASE_CYC = BREAK_BASE_MS * CLK_MHZ * 1000;
    localparam int BREAK_STEP_CYC = BREAK_STEP_MS * CLK_MHZ * 1000;
endpackage

// ### phy_diag_asserts.sv
/*
 checker for the vendor register bank, watching top ports only.
 assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/10ps
module phy_diag_asserts #(
    parameter int BREAK_BASE_CYC = 20,
    parameter int BREAK_STEP_CYC = 50,
    parameter int SAMPLE_W = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic mdc,
    input wire logic mdio_out,
    input wire logic mdio_oe_n,
    input wire logic tdr_line_break,
    input wire logic tdr_pulse_active,
    input wire logic tdr_cycle_high,
    input wire logic [5:0] tdr_tx_pattern,
    input wire logic [SAMPLE_W-1:0] tdr_sample,
    input wire logic [SAMPLE_W-1:0] tdr_sample_filt,
    input wire logic tdr_result_valid,
    input wire logic auto_crossed,
    input wire logic pair_crossed,
    input wire logic auto_crossover_en
);
    int brk_cnt_ff;
    int nxt_brk_cnt;
    logic [1:0] warm_ff;
    logic [1:0] nxt_warm;
    function automatic logic [SAMPLE_W-1:0] med3(input logic [SAMPLE_W-1:0] a, b, c);
        if ((a >= b && a <= c) || (a <= b && a >= c))
            return a;
        if ((b >= a && b <= c) || (b <= a && b >= c))
            return b;
        return c;
    endfunction
    always_comb begin
        nxt_brk_cnt = tdr_line_break ? brk_cnt_ff + 1 : 0;
        nxt_warm = (warm_ff == 2'h3) ? warm_ff : warm_ff + 2'h1;
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            brk_cnt_ff <= 0;
            warm_ff <= 2'h0;
        end else begin
            brk_cnt_ff <= nxt_brk_cnt;
            warm_ff <= nxt_warm;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_result_taken;
        tdr_pulse_active && tdr_result_valid;
    endsequence
    // three low samples: no rise close enough to move the line
    sequence s_mdc_idle;
        !mdc ##1 !mdc ##1 !mdc;
    endsequence
    a_break_length: assert property ($rose(tdr_pulse_active) |-> brk_cnt_ff >= BREAK_BASE_CYC
        && (brk_cnt_ff - BREAK_BASE_CYC) % BREAK_STEP_CYC == 0 && brk_cnt_ff <= BREAK_BASE_CYC + 7 * BREAK_STEP_CYC)
        else $error("line break length off");
    a_pulse_after_break: assert property ($rose(tdr_pulse_active) |-> $past(tdr_line_break))
        else $error("pulses without break");
    a_break_pulse_excl: assert property (!(tdr_line_break && tdr_pulse_active))
        else $error("break and pulses overlap");
    a_pattern_hold: assert property (tdr_pulse_active && $past(tdr_pulse_active) && $past(tdr_pulse_active, 2)
        && ($past(tdr_cycle_high) == $past(tdr_cycle_high, 2)) |-> $stable(tdr_tx_pattern))
        else $error("pattern moved in one cycle kind");
    a_filter_output: assert property (warm_ff == 2'h3 |-> tdr_sample_filt == $past(tdr_sample)
        || tdr_sample_filt == med3($past(tdr_sample), $past(tdr_sample, 2), $past(tdr_sample, 3)))
        else $error("filtered sample neither raw nor median");
    a_result_ends_test: assert property (s_result_taken |=> !tdr_pulse_active && !tdr_line_break)
        else $error("test kept running after result");
    a_xover_auto: assert property (auto_crossover_en |-> pair_crossed == auto_crossed)
        else $error("auto crossover not followed");
    a_mdio_idle_stable: assert property (s_mdc_idle |-> $stable(mdio_out) && $stable(mdio_oe_n))
        else $error("management line moved without clock");
    a_mdio_drive_start: assert property ($fell(mdio_oe_n) |-> $past(mdc) || $past(mdc, 2))
        else $error("drive began without clock rise");
endmodule
bind phy_cable_diag_vendor_regs phy_diag_asserts #(.BREAK_BASE_CYC(BREAK_BASE_CYC),
    .BREAK_STEP_CYC(BREAK_STEP_CYC), .SAMPLE_W(SAMPLE_W)) chk (.clock(clock), .rst_n(rst_n), .mdc(mdc),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .tdr_line_break(tdr_line_break),
    .tdr_pulse_active(tdr_pulse_active), .tdr_cycle_high(tdr_cycle_high), .tdr_tx_pattern(tdr_tx_pattern),
    .tdr_sample(tdr_sample), .tdr_sample_filt(tdr_sample_filt), .tdr_result_valid(tdr_result_valid),
    .auto_crossed(auto_crossed), .pair_crossed(pair_crossed), .auto_crossover_en(auto_crossover_en));

// ### mgmt_station.sv
/*
 station management controller model: frames on mdc and the data line.
 assumes a pull-up on the shared data line; mdc stands still between frames.
*/
`timescale 1ns/10ps
module mgmt_station (
    input wire logic clock,
    output logic mdc,
    output logic mdio_in,
    input wire logic mdio_out,
    input wire logic mdio_oe_n
);
    logic host_drv;
    logic host_bit;
    logic wire_level;
    assign wire_level = mdio_oe_n ? 1'b1 : mdio_out;
    assign mdio_in = host_drv ? host_bit : wire_level;
    initial begin
        mdc = 1'b0;
        host_drv = 1'b1;
        host_bit = 1'b1;
    end
    // data set while mdc low, line sampled just before the rise
    task automatic bit_cycle(input logic b, output logic s);
        @(posedge clock);
        #1;
        mdc = 1'b0;
        host_bit = b;
        repeat (3) @(posedge clock);
        #1;
        s = wire_level;
        mdc = 1'b1;
        @(posedge clock);
        #1;
    endtask
    task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] f;
        logic s;
        int i;
        f = {32'hffffffff, phy_diag_pkg::FRAME_START, op, pa, ra, 2'h2, wd};
        rd = 16'h0000;
        for (i = 63; i >= 0; i--) begin
            if (op == phy_diag_pkg::OP_READ && i == 17)
                host_drv = 1'b0;
            bit_cycle(f[i], s);
            if (i < 16)
                rd[i] = s;
        end
        host_drv = 1'b1;
        repeat (2) @(posedge clock);
        #1;
    endtask
endmodule

// ### tb.sv
/*
 testbench for the vendor register bank: register reads and writes, cable test, tally.
 assumes the station model of mgmt_station.sv and the bound checker.
*/
`timescale 1ns/10ps
module tb;
    localparam int BASE = 500;
    localparam int STEP = 300;
    logic clock, rst_n, mdc, mdio_in, mdio_out, mdio_oe_n;
    logic [4:0] station_address;
    logic tdr_line_break, tdr_pulse_active, tdr_cycle_high, tdr_result_valid;
    logic [5:0] tdr_tx_pattern;
    logic [7:0] tdr_sample, tdr_sample_filt, tdr_result_length;
    logic [1:0] tdr_result_type;
    logic link_100tx, link_10t, rx_in_packet, rx_symbol_invalid, auto_crossed;
    logic pair_crossed, auto_crossover_en, heartbeat_test_en, rx_polarity_reversed;
    logic [3:0] cable_length_in;
    logic [15:0] rd;
    int num_errors, checks, n;
    phy_cable_diag_vendor_regs #(.BREAK_BASE_CYC(BASE), .BREAK_STEP_CYC(STEP)) dut (.clock(clock), .rst_n(rst_n),
        .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .station_address(station_address),
        .tdr_line_break(tdr_line_break), .tdr_pulse_active(tdr_pulse_active), .tdr_cycle_high(tdr_cycle_high),
        .tdr_tx_pattern(tdr_tx_pattern), .tdr_sample(tdr_sample), .tdr_sample_filt(tdr_sample_filt),
        .tdr_result_valid(tdr_result_valid), .tdr_result_type(tdr_result_type),
        .tdr_result_length(tdr_result_length), .link_100tx(link_100tx), .link_10t(link_10t),
        .rx_in_packet(rx_in_packet), .rx_symbol_invalid(rx_symbol_invalid), .auto_crossed(auto_crossed),
        .pair_crossed(pair_crossed), .auto_crossover_en(auto_crossover_en), .heartbeat_test_en(heartbeat_test_en),
        .rx_polarity_reversed(rx_polarity_reversed), .cable_length_in(cable_length_in));
    mgmt_station mgr (.clock(clock), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n));
    always #4 clock = ~clock;
    task automatic tally_and_finish;
        if (num_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        mgr.xfer(phy_diag_pkg::OP_WRITE, station_address, ra, d, rd);
    endtask
    task automatic rdc(input logic [4:0] ra, input logic [15:0] exp);
        mgr.xfer(phy_diag_pkg::OP_READ, station_address, ra, 16'h0000, rd);
        check(rd, exp);
    endtask
    task automatic step;
        @(posedge clock);
        #1;
    endtask
    // counts high cycles of the line break; a missing break ends the run
    task automatic measure_break(input int exp);
        int i;
        n = 0;
        for (i = 0; i < 2000 && tdr_line_break !== 1'b1; i++)
            step();
        if (i == 2000) begin
            num_errors++;
            tally_and_finish();
        end
        while (tdr_line_break === 1'b1 && n < 4000) begin
            step();
            n++;
        end
        check(16'(n), 16'(exp));
    endtask
    task automatic pulse_sym(input int k);
        repeat (k) begin
            rx_symbol_invalid = 1'b1;
            step();
            rx_symbol_invalid = 1'b0;
            step();
        end
    endtask
    task automatic tdr_result(input logic [1:0] t, input logic [7:0] len);
        tdr_result_type = t;
        tdr_result_length = len;
        tdr_result_valid = 1'b1;
        step();
        tdr_result_valid = 1'b0;
        check(16'(tdr_pulse_active), 16'h0000);
    endtask
    initial begin
        {clock, rst_n, tdr_cycle_high, tdr_result_valid, link_10t, rx_in_packet, rx_symbol_invalid} = 7'h00;
        {link_100tx, rx_polarity_reversed} = 2'h3;
        station_address = 5'h05;
        tdr_sample = 8'h00;
        tdr_result_type = 2'h0;
        tdr_result_length = 8'h00;
        auto_crossed = 1'b0;
        cable_length_in = 4'h9;
        repeat (8) @(posedge clock);
        #1;
        rst_n = 1'b1;
        repeat (2) step();
        check(16'({auto_crossover_en, heartbeat_test_en, pair_crossed}), 16'h0006);
        rdc(phy_diag_pkg::IDX_TDR_PATTERN_DELAY_CTRL, 16'h0b9d);
        rdc(phy_diag_pkg::IDX_TDR_CTRL_STATUS, 16'h0000);
        rdc(phy_diag_pkg::IDX_SYMBOL_ERROR_COUNTER, 16'h0000);
        rdc(phy_diag_pkg::IDX_CROSSOVER_SQE_POLARITY_CTRL, 16'h0010);
        rdc(phy_diag_pkg::IDX_CABLE_LENGTH_ESTIMATE, 16'h9000);
        wr(phy_diag_pkg::IDX_CROSSOVER_SQE_POLARITY_CTRL, 16'hffff);
        rdc(phy_diag_pkg::IDX_CROSSOVER_SQE_POLARITY_CTRL, 16'ha810);
        check(16'({auto_crossover_en, heartbeat_test_en, pair_crossed}), 16'h0001);
        auto_crossed = 1'b1;
        wr(phy_diag_pkg::IDX_CROSSOVER_SQE_POLARITY_CTRL, 16'h8000);
        check(16'(pair_crossed), 16'h0000);
        wr(phy_diag_pkg::IDX_CROSSOVER_SQE_POLARITY_CTRL, 16'h0000);
        check(16'(pair_crossed), 16'h0001);
        // foreign station: no write, no drive, pull-up reads all ones
        mgr.xfer(phy_diag_pkg::OP_WRITE, 5'h04, phy_diag_pkg::IDX_CROSSOVER_SQE_POLARITY_CTRL, 16'h8800, rd);
        mgr.xfer(phy_diag_pkg::OP_READ, 5'h04, phy_diag_pkg::IDX_CROSSOVER_SQE_POLARITY_CTRL, 16'h0000, rd);
        check(rd, 16'hffff);
        rdc(phy_diag_pkg::IDX_CROSSOVER_SQE_POLARITY_CTRL, 16'h0010);
        wr(phy_diag_pkg::IDX_TDR_PATTERN_DELAY_CTRL, 16'ha56a);
        fork
            measure_break(BASE + 2 * STEP);
            wr(phy_diag_pkg::IDX_TDR_CTRL_STATUS, 16'hc000);
        join
        check(16'(tdr_pulse_active), 16'h0001);
        tdr_cycle_high = 1'b1;
        tdr_sample = 8'h0a;
        step();
        tdr_sample = 8'h0c;
        step();
        check(16'(tdr_tx_pattern), 16'h0015);
        tdr_cycle_high = 1'b0;
        tdr_sample = 8'hc8;
        step();
        check(16'(tdr_tx_pattern), 16'h002a);
        check(16'(tdr_sample_filt), 16'h000c);
        tdr_result(phy_diag_pkg::CABLE_SHORT, 8'h37);
        rdc(phy_diag_pkg::IDX_TDR_CTRL_STATUS, 16'h4337);
        // counter ignored while extension is off
        wr(phy_diag_pkg::IDX_TDR_PATTERN_DELAY_CTRL, 16'h3b9d);
        fork
            measure_break(BASE);
            begin
                wr(phy_diag_pkg::IDX_TDR_CTRL_STATUS, 16'h8000);
                rdc(phy_diag_pkg::IDX_TDR_CTRL_STATUS, 16'h8000);
            end
        join
        tdr_result(phy_diag_pkg::CABLE_MATCH, 8'h55);
        rdc(phy_diag_pkg::IDX_TDR_CTRL_STATUS, 16'h0700);
        pulse_sym(3);
        rx_in_packet = 1'b1;
        pulse_sym(3);
        rx_in_packet = 1'b0;
        {link_100tx, link_10t} = 2'h1;
        rdc(phy_diag_pkg::IDX_CABLE_LENGTH_ESTIMATE, 16'h0000);
        pulse_sym(2);
        {link_100tx, link_10t} = 2'h2;
        step();
        rdc(phy_diag_pkg::IDX_SYMBOL_ERROR_COUNTER, 16'h0004);
        rdc(phy_diag_pkg::IDX_SYMBOL_ERROR_COUNTER, 16'h0004);
        rx_symbol_invalid = 1'b1;
        repeat (65531) @(posedge clock);
        #1;
        rx_symbol_invalid = 1'b0;
        rdc(phy_diag_pkg::IDX_SYMBOL_ERROR_COUNTER, 16'hffff);
        pulse_sym(1);
        rdc(phy_diag_pkg::IDX_SYMBOL_ERROR_COUNTER, 16'h0000);
        tally_and_finish();
    end
endmodule
